//--- rtl/mcu_interrupt_unit.sv
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - No request accepted while global enable clear.
// - Accept: jump to vector 8, stack deepens.
// - Global enable readable, writable; one permits service.
// - Save/restore copies accumulator and flags.
// - Single buffer level; timeout, powerdown bits untouched.
// - External edge sets its flag regardless.
// - Enabled external edge vectors to address 8.
// - Power-down wake edge latched, serviced first.
// - Edge select: reserved, rise, fall, both.
// - Timer 0 overflow sets its flag always.
// - Timer 0 vectors only when enabled.
// - Timer/counter 0 overflow sets its flag always.
// - Disabled timer/counter overflow never vectors later.
// - Entry clears global enable; exit sets it.
// - Return instruction ends service.
// - Bits: external 0, timer 4, timer/counter 5.
module mcu_interrupt_unit (
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Classic Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // External interrupt line, sampled on clk_sys.
  input wire logic ext_irq_line,
  // Core sequencer and timers.
  input wire irq_pkg::core_in_s core_in,
  output irq_pkg::core_out_s core_out
);
  import irq_pkg::*;

  // Register index match, used by both the read and the write path.
  function automatic logic idx_hit(input logic [31:0] adr, input logic [7:0] idx);
    idx_hit = (adr[ADR_MSB:ADR_LSB] == idx) && (adr[ADR_LSB-1:0] == '0);
  endfunction : idx_hit

  // Software-visible state.
  logic [REG_W-1:0] stack_and_global_enable_reg, stack_and_global_enable_next; // Global enable and stack level.
  logic [REG_W-1:0] edge_reg, edge_next; // Edge selection field.
  logic [REG_W-1:0] ien_reg, ien_next; // Per-source enables.
  logic [REG_W-1:0] irq_reg, irq_next; // Per-source request flags.
  // Internal service state.
  svc_state_e state_reg, state_next;
  logic tc0_armed_reg, tc0_armed_next; // Timer/counter overflow seen while enabled.
  logic wake_reg, wake_next; // Wake-up edge latch.
  logic vtake_reg, vtake_next; // Vector entry pulse.
  logic ret_reg, ret_next; // Service exit pulse.
  // Bus answer.
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;

  logic ext_edge; // Qualifying edge this cycle.
  logic wr_stb; // Bus write taken this cycle.
  logic req_any; // Some enabled source or the wake latch is pending.
  logic ctx_valid;
  logic [REG_W-1:0] ctx_acc;
  logic [REG_W-1:0] ctx_flags;

  // Detects the selected edge on the external line.
  ext_edge_detect u_edge (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .line_in(ext_irq_line),
    .edge_sel(edge_sel_e'(edge_reg[EDGE_LO +: 2])),
    .edge_pulse(ext_edge)
  );

  // Holds one level of accumulator and flag context.
  context_buffer u_ctx (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .save_ctx(core_in.save_ctx),
    .restore_ctx(core_in.restore_ctx),
    .acc_in(core_in.accumulator),
    .flags_in(core_in.proc_flags),
    .restore_valid(ctx_valid),
    .acc_out(ctx_acc),
    .flags_out(ctx_flags)
  );

  // Bus write strobe: taken in the request cycle, before the ack is raised, low byte lane only.
  assign wr_stb = wb_cyc_i & wb_stb_i & ~ack_reg & wb_we_i & wb_sel_i[0];

  // Answers every access one cycle after the request, mapped or not.
  always_comb begin
    ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
    dat_next = dat_reg;
    if (wb_cyc_i & wb_stb_i & ~ack_reg & ~wb_we_i) begin
      dat_next = '0; // Unmapped indexes read zero.
      if (idx_hit(wb_adr_i, IDX_STACK_AND_GLOBAL_ENABLE)) begin
        dat_next[REG_W-1:0] = stack_and_global_enable_reg & STACK_AND_GLOBAL_ENABLE_MASK;
      end else if (idx_hit(wb_adr_i, IDX_EDGE)) begin
        dat_next[REG_W-1:0] = edge_reg & EDGE_MASK;
      end else if (idx_hit(wb_adr_i, IDX_IRQ_EN)) begin
        dat_next[REG_W-1:0] = ien_reg & IRQ_MASK;
      end else if (idx_hit(wb_adr_i, IDX_IRQ_REQ)) begin
        dat_next[REG_W-1:0] = irq_reg & IRQ_MASK;
      end else if (idx_hit(wb_adr_i, IDX_STATUS)) begin
        dat_next[ST_SERVICE] = (state_reg == SVC_ACTIVE);
        dat_next[ST_WAKE] = wake_reg;
      end
    end
  end

  // External and timer 0 count as pending with flag and enable set; timer/counter when armed, wake whenever latched.
  always_comb begin
    req_any = (irq_reg[EXT_BIT] & ien_reg[EXT_BIT])
      | (irq_reg[T0_BIT] & ien_reg[T0_BIT])
      | tc0_armed_reg
      | wake_reg;
  end

  // Computes the next register, flag and service state.
  always_comb begin
    stack_and_global_enable_next = stack_and_global_enable_reg;
    edge_next = edge_reg;
    ien_next = ien_reg;
    irq_next = irq_reg;
    state_next = state_reg;
    tc0_armed_next = tc0_armed_reg;
    wake_next = wake_reg;
    vtake_next = 1'b0;
    ret_next = 1'b0;
    // Software writes come first so that hardware events below win.
    if (wr_stb) begin
      if (idx_hit(wb_adr_i, IDX_STACK_AND_GLOBAL_ENABLE)) begin
        stack_and_global_enable_next = wb_dat_i[REG_W-1:0] & STACK_AND_GLOBAL_ENABLE_MASK;
      end
      if (idx_hit(wb_adr_i, IDX_EDGE)) begin
        edge_next = wb_dat_i[REG_W-1:0] & EDGE_MASK;
      end
      if (idx_hit(wb_adr_i, IDX_IRQ_EN)) begin
        ien_next = wb_dat_i[REG_W-1:0] & IRQ_MASK;
      end
      if (idx_hit(wb_adr_i, IDX_IRQ_REQ)) begin
        irq_next = wb_dat_i[REG_W-1:0] & IRQ_MASK;
      end
    end
    // Events set flags whatever the enables say; a set beats a clear.
    if (ext_edge) begin
      irq_next[EXT_BIT] = 1'b1;
    end
    if (core_in.timer0_ovf) begin
      irq_next[T0_BIT] = 1'b1;
    end
    if (core_in.tc0_ovf) begin
      irq_next[TC0_BIT] = 1'b1;
    end
    // Timer/counter overflow arms service only if enabled at the event.
    if (!irq_next[TC0_BIT]) begin
      tc0_armed_next = 1'b0;
    end
    if (core_in.tc0_ovf && ien_reg[TC0_BIT]) begin
      tc0_armed_next = 1'b1;
    end
    // A matching edge during power-down is kept until serviced.
    if (core_in.powerdown && ext_edge) begin
      wake_next = 1'b1;
    end
    case (state_reg)
      SVC_IDLE: begin
        // One shared vector, taken at a boundary with the global enable set.
        if (core_in.instr_boundary && stack_and_global_enable_reg[GIE_BIT] && req_any) begin
          state_next = SVC_ACTIVE;
          vtake_next = 1'b1;
          stack_and_global_enable_next[GIE_BIT] = 1'b0;
          stack_and_global_enable_next[STK_LO +: 2] = stack_and_global_enable_reg[STK_LO +: 2] - 2'h1;
          tc0_armed_next = 1'b0;
          wake_next = 1'b0;
        end
      end
      SVC_ACTIVE: begin
        // The return instruction ends service and reopens the global enable.
        if (core_in.irq_return) begin
          state_next = SVC_IDLE;
          ret_next = 1'b1;
          stack_and_global_enable_next[GIE_BIT] = 1'b1;
          stack_and_global_enable_next[STK_LO +: 2] = stack_and_global_enable_reg[STK_LO +: 2] + 2'h1;
        end
      end
      default: begin
        state_next = SVC_IDLE;
      end
    endcase
  end

  // Registers the bus answer.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // Registers control, flags and service state.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stack_and_global_enable_reg <= STACK_AND_GLOBAL_ENABLE_RST;
      edge_reg <= EDGE_RST;
      ien_reg <= '0;
      irq_reg <= '0;
      state_reg <= SVC_IDLE;
      tc0_armed_reg <= 1'b0;
      wake_reg <= 1'b0;
      vtake_reg <= 1'b0;
      ret_reg <= 1'b0;
    end else begin
      stack_and_global_enable_reg <= stack_and_global_enable_next;
      edge_reg <= edge_next;
      ien_reg <= ien_next;
      irq_reg <= irq_next;
      state_reg <= state_next;
      tc0_armed_reg <= tc0_armed_next;
      wake_reg <= wake_next;
      vtake_reg <= vtake_next;
      ret_reg <= ret_next;
    end
  end

  // Every output field is a flip-flop or a constant.
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign core_out.vector_take = vtake_reg;
  assign core_out.vector_pc = VECTOR_ADDR;
  assign core_out.ret_take = ret_reg;
  assign core_out.in_service = (state_reg == SVC_ACTIVE);
  assign core_out.wake_pending = wake_reg;
  assign core_out.restore_valid = ctx_valid;
  assign core_out.acc_restore = ctx_acc;
  assign core_out.flags_restore = ctx_flags;

endmodule : mcu_interrupt_unit

//--- rtl/irq_pkg.sv
package irq_pkg;

  // Register width and the word index field of the Wishbone byte address.
  localparam int unsigned REG_W = 8;
  localparam int unsigned ADR_LSB = 2;
  localparam int unsigned ADR_MSB = 9;

  // Register indexes; the byte address is four times the index.
  localparam logic [7:0] IDX_EDGE = 8'hBF;
  localparam logic [7:0] IDX_STACK_AND_GLOBAL_ENABLE = 8'hDF;
  localparam logic [7:0] IDX_IRQ_REQ = 8'hC8;
  localparam logic [7:0] IDX_IRQ_EN = 8'hC9;
  localparam logic [7:0] IDX_STATUS = 8'hF0;

  // Field positions in the enable and request registers, then the stack, edge and status registers.
  localparam int unsigned EXT_BIT = 0;
  localparam int unsigned T0_BIT = 4;
  localparam int unsigned TC0_BIT = 5;
  localparam int unsigned GIE_BIT = 7;
  localparam int unsigned STK_LO = 0;
  localparam int unsigned EDGE_LO = 3;
  localparam int unsigned ST_SERVICE = 0;
  localparam int unsigned ST_WAKE = 1;

  // Implemented-bit masks; other bits read as zero.
  localparam logic [7:0] IRQ_MASK = 8'h31;
  localparam logic [7:0] STACK_AND_GLOBAL_ENABLE_MASK = 8'h83;
  localparam logic [7:0] EDGE_MASK = 8'h18;

  // Reset values.
  localparam logic [7:0] STACK_AND_GLOBAL_ENABLE_RST = 8'h03;
  localparam logic [7:0] EDGE_RST = 8'h10;

  // Processor flag bits that the context buffer never touches.
  localparam logic [7:0] PROC_FLAGS_KEEP_MASK = 8'hC0;

  // Program counter width and the common interrupt vector.
  localparam int unsigned PC_W = 12;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 12'h008;

  // External edge selection codes.
  typedef enum logic [1:0] {
    EDGE_RSVD = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_e;

  // Service state of the interrupt unit.
  typedef enum logic {
    SVC_IDLE = 1'b0,
    SVC_ACTIVE = 1'b1
  } svc_state_e;

  // Signals from the core sequencer and the timers.
  typedef struct packed {
    logic instr_boundary;
    logic save_ctx;
    logic restore_ctx;
    logic irq_return;
    logic powerdown;
    logic timer0_ovf;
    logic tc0_ovf;
    logic [REG_W-1:0] accumulator;
    logic [REG_W-1:0] proc_flags;
  } core_in_s;

  // Signals back to the core sequencer.
  typedef struct packed {
    logic vector_take;
    logic [PC_W-1:0] vector_pc;
    logic ret_take;
    logic in_service;
    logic wake_pending;
    logic restore_valid;
    logic [REG_W-1:0] acc_restore;
    logic [REG_W-1:0] flags_restore;
  } core_out_s;

endpackage : irq_pkg

//--- rtl/ext_edge_detect.sv
`timescale 1ns/1ps
// Turns the sampled external line into a one-cycle qualifying-edge pulse.
module ext_edge_detect (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic line_in,
  input wire irq_pkg::edge_sel_e edge_sel,
  output logic edge_pulse
);
  import irq_pkg::*;

  logic prev_reg; // Line level one cycle ago.
  logic prev_next;
  logic rise; // Low to high this cycle.
  logic fall; // High to low this cycle.
  logic hit; // Edge matches the selection.

  // Compares the line with its last level and applies the edge selection.
  always_comb begin
    prev_next = line_in;
    rise = line_in & ~prev_reg;
    fall = ~line_in & prev_reg;
    case (edge_sel)
      EDGE_RISE: hit = rise;
      EDGE_FALL: hit = fall;
      EDGE_BOTH: hit = rise | fall;
      default: hit = 1'b0; // Reserved code detects nothing.
    endcase
  end

  // Registers the line level; it resets low so a line high after reset reads as a rising edge.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign edge_pulse = hit;

endmodule : ext_edge_detect

//--- rtl/context_buffer.sv
`timescale 1ns/1ps
// One-level save and restore buffer for the accumulator and processor flags.
module context_buffer (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic save_ctx,
  input wire logic restore_ctx,
  input wire logic [irq_pkg::REG_W-1:0] acc_in,
  input wire logic [irq_pkg::REG_W-1:0] flags_in,
  output logic restore_valid,
  output logic [irq_pkg::REG_W-1:0] acc_out,
  output logic [irq_pkg::REG_W-1:0] flags_out
);
  import irq_pkg::*;

  logic [REG_W-1:0] acc_buf_reg, acc_buf_next; // Saved accumulator.
  logic [REG_W-1:0] flg_buf_reg, flg_buf_next; // Saved flags.
  logic valid_reg, valid_next; // Restore strobe to the core.
  logic [REG_W-1:0] acc_out_reg, acc_out_next;
  logic [REG_W-1:0] flg_out_reg, flg_out_next;

  // A save overwrites the single slot; a restore hands it back.
  always_comb begin
    acc_buf_next = acc_buf_reg;
    flg_buf_next = flg_buf_reg;
    valid_next = 1'b0;
    acc_out_next = acc_out_reg;
    flg_out_next = flg_out_reg;
    if (save_ctx) begin
      acc_buf_next = acc_in;
      flg_buf_next = flags_in & ~PROC_FLAGS_KEEP_MASK;
    end
    if (restore_ctx) begin
      valid_next = 1'b1;
      acc_out_next = acc_buf_reg;
      // Timeout and power-down bits pass through from the live flags.
      flg_out_next = (flg_buf_reg & ~PROC_FLAGS_KEEP_MASK) | (flags_in & PROC_FLAGS_KEEP_MASK);
    end
  end

  // Registers the buffer and the restore outputs.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      acc_buf_reg <= '0;
      flg_buf_reg <= '0;
      valid_reg <= 1'b0;
      acc_out_reg <= '0;
      flg_out_reg <= '0;
    end else begin
      acc_buf_reg <= acc_buf_next;
      flg_buf_reg <= flg_buf_next;
      valid_reg <= valid_next;
      acc_out_reg <= acc_out_next;
      flg_out_reg <= flg_out_next;
    end
  end

  assign restore_valid = valid_reg;
  assign acc_out = acc_out_reg;
  assign flags_out = flg_out_reg;

endmodule : context_buffer

//--- bench/mcu_interrupt_unit_properties.sv
`timescale 1ns/1ps
// Watches the register handshake and the core link of the interrupt unit.
module irq_unit_checker
  import irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire irq_pkg::core_in_s core_in,
  input wire irq_pkg::core_out_s core_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // A return leaves service with one pulse.
  sequence s_ret_done;
    core_out.ret_take && !core_out.in_service;
  endsequence
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer too long");
  AST_VEC_PC: assert property (core_out.vector_take |-> core_out.vector_pc == VECTOR_ADDR)
    else $error("wrong vector");
  AST_VEC_SVC: assert property (core_out.vector_take |-> core_out.in_service)
    else $error("entry without service");
  AST_NO_NEST: assert property ($past(core_out.in_service) |-> !core_out.vector_take)
    else $error("vector during service");
  AST_BOUNDARY: assert property (core_out.vector_take |-> $past(core_in.instr_boundary))
    else $error("vector off boundary");
  AST_RET: assert property (core_in.irq_return && core_out.in_service |=> s_ret_done)
    else $error("return not taken");
  AST_RET_SVC: assert property (core_out.ret_take |-> $past(core_out.in_service))
    else $error("return outside service");
  AST_RESTORE: assert property (core_in.restore_ctx |=> core_out.restore_valid)
    else $error("restore missing");
  AST_KEEP_FLAGS: assert property (core_out.restore_valid |->
    core_out.flags_restore[7:6] == $past(core_in.proc_flags[7:6]))
    else $error("kept flag bits changed");
endmodule : irq_unit_checker

bind mcu_interrupt_unit irq_unit_checker u_irq_unit_checker (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .core_in(core_in), .core_out(core_out));

//--- bench/core_model.sv
`timescale 1ns/1ps
// Stands for the core sequencer and timers; it registers requests onto the link.
module core_model
  import irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic slow,
  input wire irq_pkg::core_in_s req,
  output irq_pkg::core_in_s core_in
);
  logic [1:0] cnt_reg; // Cycle inside a slow four-cycle instruction.
  // In slow mode only every fourth cycle ends an instruction.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 2'h0;
      core_in <= '0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      core_in <= {(!slow || cnt_reg == 2'h3), req[$bits(core_in_s)-2:0]};
    end
  end
endmodule : core_model

//--- bench/mcu_interrupt_unit_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the interrupt unit.
module mcu_interrupt_unit_bench;
  import irq_pkg::*;
  // One register access and the value a read should then return.
  typedef struct {
    logic [7:0] idx;
    logic we;
    logic [7:0] d;
    logic [7:0] exp;
  } row_s;
  localparam int P_SAVE = 0, P_REST = 1, P_RET = 2, P_T0 = 3, P_TC0 = 4;
  logic clk_sys;
  logic sys_rst;
  logic cyc;
  logic we;
  logic [31:0] adr;
  logic [31:0] dat;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic line;
  logic slow;
  core_in_s req;
  core_in_s core_in;
  core_out_s core_out;
  int miscompares = 0;
  int n_compared = 0;
  int n_vec = 0;
  int n_ret = 0;
  row_s rows[17] = '{'{IDX_STACK_AND_GLOBAL_ENABLE, 1'h0, 8'h00, STACK_AND_GLOBAL_ENABLE_RST}, '{IDX_EDGE, 1'h0, 8'h00, EDGE_RST},
    '{IDX_IRQ_REQ, 1'h0, 8'h00, 8'h00}, '{IDX_IRQ_EN, 1'h0, 8'h00, 8'h00},
    '{IDX_EDGE, 1'h1, 8'h08, 8'h08}, '{IDX_EDGE, 1'h1, 8'h18, 8'h18}, '{IDX_EDGE, 1'h1, 8'h00, 8'h00},
    '{IDX_EDGE, 1'h1, 8'hFF, 8'h18}, '{IDX_EDGE, 1'h1, 8'h10, 8'h10}, '{IDX_IRQ_EN, 1'h1, 8'hFF, 8'h31},
    '{IDX_IRQ_EN, 1'h1, 8'h00, 8'h00}, '{IDX_IRQ_REQ, 1'h1, 8'hFF, 8'h31},
    '{IDX_IRQ_REQ, 1'h1, 8'h00, 8'h00}, '{IDX_STACK_AND_GLOBAL_ENABLE, 1'h1, 8'hFF, 8'h83},
    '{IDX_STACK_AND_GLOBAL_ENABLE, 1'h1, 8'h03, 8'h03}, '{8'h10, 1'h1, 8'hFF, 8'h00}, '{IDX_STATUS, 1'h0, 8'h00, 8'h00}};

  mcu_interrupt_unit u_mcu_interrupt_unit (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_irq_line(line), .core_in(core_in), .core_out(core_out));
  core_model u_core_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow), .req(req), .core_in(core_in));

  // Makes the 100 MHz clock.
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Counts vector entries and returns.
  always @(posedge clk_sys) begin
    if (core_out.vector_take === 1'h1) n_vec <= n_vec + 1;
    if (core_out.ret_take === 1'h1) n_ret <= n_ret + 1;
  end

  task automatic wrap_up();
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask : settle

  // One classic bus cycle, held until the answer is sampled.
  task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [7:0] q);
    int k;
    @(posedge clk_sys);
    cyc <= 1'h1;
    we <= w;
    adr <= {22'h0, i, 2'h0};
    dat <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wb_ack_o !== 1'h1 && k < 20);
    q = wb_dat_o[7:0];
    cyc <= 1'h0;
    if (k >= 20) begin
      miscompares++;
      wrap_up();
    end
  endtask : wb

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    wb(1'h1, i, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] q;
    wb(1'h0, i, 8'h00, q);
    chk(q, e);
  endtask : rd

  // Sends one core or timer pulse with the given accumulator and flags.
  task automatic pulse(input int n, input logic [7:0] a, input logic [7:0] f);
    core_in_s v;
    v = '0;
    v.save_ctx = (n == P_SAVE);
    v.restore_ctx = (n == P_REST);
    v.irq_return = (n == P_RET);
    v.timer0_ovf = (n == P_T0);
    v.tc0_ovf = (n == P_TC0);
    v.accumulator = a;
    v.proc_flags = f;
    @(posedge clk_sys);
    req <= v;
    @(posedge clk_sys);
    req <= '0;
    settle();
  endtask : pulse

  task automatic set_line(input logic v);
    @(posedge clk_sys);
    line <= v;
    settle();
  endtask : set_line

  // Software clears its flags and enables, then returns.
  task automatic leave_isr();
    wr(IDX_IRQ_REQ, 8'h00);
    wr(IDX_IRQ_EN, 8'h00);
    pulse(P_RET, 8'h00, 8'h00);
  endtask : leave_isr

  // Register table first, then the event scenarios.
  initial begin
    sys_rst = 1'h1;
    cyc = 1'h0;
    we = 1'h0;
    adr = 32'h0;
    dat = 32'h0;
    line = 1'h0;
    slow = 1'h0;
    req = '0;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'h0;
    foreach (rows[r]) begin
      if (rows[r].we === 1'h1) wr(rows[r].idx, rows[r].d);
      rd(rows[r].idx, rows[r].exp);
    end
    // Timer 0 overflow with its enable clear sets the flag; setting the enable later vectors.
    wr(IDX_STACK_AND_GLOBAL_ENABLE, 8'h83);
    pulse(P_T0, 8'h00, 8'h00);
    rd(IDX_IRQ_REQ, 8'h10);
    chk(8'(n_vec), 8'h00);
    wr(IDX_IRQ_EN, 8'h10);
    settle();
    chk(8'(n_vec), 8'h01);
    rd(IDX_STACK_AND_GLOBAL_ENABLE, 8'h02);
    rd(IDX_STATUS, 8'h01);
    leave_isr();
    rd(IDX_STACK_AND_GLOBAL_ENABLE, 8'h83);
    chk(8'(n_ret), 8'h01);
    // A timer/counter overflow seen while disabled never vectors later.
    slow <= 1'h1;
    pulse(P_TC0, 8'h00, 8'h00);
    rd(IDX_IRQ_REQ, 8'h20);
    wr(IDX_IRQ_EN, 8'h20);
    settle();
    chk(8'(n_vec), 8'h01);
    wr(IDX_IRQ_REQ, 8'h00);
    pulse(P_TC0, 8'h00, 8'h00);
    chk(8'(n_vec), 8'h02);
    leave_isr();
    slow <= 1'h0;
    // The external edge sets its flag but cannot vector while global enable is clear.
    wr(IDX_STACK_AND_GLOBAL_ENABLE, 8'h03);
    wr(IDX_IRQ_EN, 8'h01);
    set_line(1'h1);
    rd(IDX_IRQ_REQ, 8'h00);
    set_line(1'h0);
    rd(IDX_IRQ_REQ, 8'h01);
    chk(8'(n_vec), 8'h02);
    wr(IDX_STACK_AND_GLOBAL_ENABLE, 8'h83);
    settle();
    chk(8'(n_vec), 8'h03);
    leave_isr();
    // A matching edge during power-down is latched and serviced while power-down is still set.
    req.powerdown <= 1'h1;
    set_line(1'h1);
    set_line(1'h0);
    req.powerdown <= 1'h0;
    settle();
    chk(8'(n_vec), 8'h04);
    chk(8'(core_out.wake_pending), 8'h00);
    leave_isr();
    // The newest save replaces the older one; kept flag bits come from the live flags.
    pulse(P_SAVE, 8'hA5, 8'hFF);
    pulse(P_REST, 8'h00, 8'h40);
    chk(core_out.acc_restore, 8'hA5);
    chk(core_out.flags_restore, 8'h7F);
    pulse(P_SAVE, 8'h3C, 8'h00);
    pulse(P_SAVE, 8'h5A, 8'h15);
    pulse(P_REST, 8'h00, 8'h80);
    chk(core_out.acc_restore, 8'h5A);
    chk(core_out.flags_restore, 8'h95);
    // A reset in mid-run restores the register values.
    @(posedge clk_sys);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(IDX_STACK_AND_GLOBAL_ENABLE, STACK_AND_GLOBAL_ENABLE_RST);
    rd(IDX_EDGE, EDGE_RST);
    wrap_up();
  end
endmodule : mcu_interrupt_unit_bench
